/* File: hw/reset_strap_mode_sampler.sv */
// Strap capture during device reset, mode application after it, and an AXI4-Lite slave.
// Assumes board pulls or external logic set the strap pins while the device reset is low.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - While the device reset is asserted every strap input is sampled and the capture sets the modes.
// - An undriven strap, held low by the weak pull-down, is captured as zero.
// - A boot strap of zero starts the boot from external memory as soon as reset ends.
// - A boot strap of one leaves the device idle after reset until an outside master releases it.
// - An interrupt strap of zero leaves the four interrupt inputs disabled and level sensitive.
// - An interrupt strap of one enables the four interrupt inputs as edge sensitive at reset release.
module reset_strap_mode_sampler
  import strap_sampler_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic I_CORE_RESET_B,
  input wire logic [STRAP_COUNT-1:0] I_STRAP_PIN,
  input wire logic [STRAP_COUNT-1:0] I_PIN_FUNCTION,
  output logic [STRAP_COUNT-1:0] O_STRAP_PIN,
  output logic [STRAP_COUNT-1:0] O_STRAP_PIN_OE,
  output logic O_BOOT_START,
  output logic O_CORE_RUN,
  output logic [EXT_IRQ_COUNT-1:0] O_EXT_IRQ_ENABLE,
  output logic [EXT_IRQ_COUNT-1:0] O_EXT_IRQ_EDGE,
  output logic O_TEST_STRAP_FAULT,
  input wire logic [AXI_ADDR_W-1:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [31:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [AXI_ADDR_W-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [31:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic core_reset_b_sync;
  logic [STRAP_COUNT-1:0] strap_sync;
  logic in_reset;

  // Reset and straps share one latency, so the last capture matches the last reset cycle.
  strap_pin_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_reset_sync (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_pin(I_CORE_RESET_B),
    .o_level(core_reset_b_sync)
  );

  strap_pin_sync #(.WIDTH(STRAP_COUNT), .RESET_VAL(STRAP_DEFAULT)) u_strap_sync (
    .i_clk(I_REF_CLK),
    .i_rst_b(I_RST_B),
    .i_pin(I_STRAP_PIN),
    .o_level(strap_sync)
  );

  assign in_reset = !core_reset_b_sync;

  // ************************************************************
  // Strap capture and boot sequencer
  // ************************************************************
  boot_state_t state;
  boot_state_t next_state;
  logic [STRAP_COUNT-1:0] captured;
  logic [STRAP_COUNT-1:0] next_captured;
  logic next_boot_start;
  logic next_core_run;
  logic [EXT_IRQ_COUNT-1:0] next_irq_enable;
  logic [EXT_IRQ_COUNT-1:0] next_irq_edge;
  logic [STRAP_COUNT-1:0] next_pin_out;
  logic [STRAP_COUNT-1:0] next_pin_oe;
  logic next_test_fault;
  logic boot_release;

  always_comb begin
    next_state = state;
    next_captured = captured;
    if (in_reset) begin
      next_captured = strap_sync;
      next_state = ST_RESET;
    end else begin
      unique case (state)
        ST_RESET: begin
          if (captured[STRAP_BOOT]) begin
            next_state = ST_IDLE_WAIT;
          end else begin
            next_state = ST_BOOT_MEM;
          end
        end
        ST_BOOT_MEM: begin
          next_state = ST_RUN;
        end
        ST_IDLE_WAIT: begin
          if (boot_release) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          next_state = ST_RUN;
        end
      endcase
    end
    next_boot_start = (next_state == ST_BOOT_MEM);
    next_core_run = (next_state == ST_BOOT_MEM) || (next_state == ST_RUN);
    // Interrupt modes follow the capture only once reset has ended.
    next_irq_enable = '0;
    next_irq_edge = '0;
    if (next_state != ST_RESET && captured[STRAP_IRQ]) begin
      next_irq_enable = '1;
      next_irq_edge = '1;
    end
    // Shared pins float during reset so the straps can be read, then resume their normal use.
    next_pin_oe = (next_state == ST_RESET) ? '0 : '1;
    next_pin_out = (next_state == ST_RESET) ? '0 : I_PIN_FUNCTION;
    // Reserved test straps are only reported; the device cannot stop a board from driving them.
    next_test_fault = next_captured[STRAP_TEST_A] | next_captured[STRAP_TEST_B];
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= ST_RESET;
      captured <= STRAP_DEFAULT;
      O_BOOT_START <= 1'b0;
      O_CORE_RUN <= 1'b0;
      O_EXT_IRQ_ENABLE <= '0;
      O_EXT_IRQ_EDGE <= '0;
      O_STRAP_PIN <= '0;
      O_STRAP_PIN_OE <= '0;
      O_TEST_STRAP_FAULT <= 1'b0;
    end else begin
      state <= next_state;
      captured <= next_captured;
      O_BOOT_START <= next_boot_start;
      O_CORE_RUN <= next_core_run;
      O_EXT_IRQ_ENABLE <= next_irq_enable;
      O_EXT_IRQ_EDGE <= next_irq_edge;
      O_STRAP_PIN <= next_pin_out;
      O_STRAP_PIN_OE <= next_pin_oe;
      O_TEST_STRAP_FAULT <= next_test_fault;
    end
  end

  // ************************************************************
  // AXI4-Lite register slave
  // ************************************************************
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [AXI_ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_boot_release;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[STATUS_CAPTURED_LSB +: STRAP_COUNT] = captured;
    status_word[STATUS_IN_RESET] = in_reset;
    status_word[STATUS_IDLE_WAIT] = (state == ST_IDLE_WAIT);
    status_word[STATUS_CORE_RUN] = O_CORE_RUN;
    status_word[STATUS_TEST_FAULT] = O_TEST_STRAP_FAULT;
  end

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = O_S_AXI_BVALID;
    next_bresp = O_S_AXI_BRESP;
    next_boot_release = 1'b0;
    if (O_S_AXI_BVALID && I_S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (I_S_AXI_AWVALID && O_S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = I_S_AXI_AWADDR;
    end
    if (I_S_AXI_WVALID && O_S_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = I_S_AXI_WDATA;
      next_w_strb = I_S_AXI_WSTRB;
    end
    if (aw_held && w_held && !O_S_AXI_BVALID) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_addr[AXI_ADDR_W-1:2] == OFFSET_CONTROL[AXI_ADDR_W-1:2]) begin
        next_boot_release = w_strb[0] && w_data[CONTROL_BOOT_RELEASE];
      end else if (aw_addr[AXI_ADDR_W-1:2] != OFFSET_STATUS[AXI_ADDR_W-1:2]) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    next_rvalid = O_S_AXI_RVALID;
    next_rdata = O_S_AXI_RDATA;
    next_rresp = O_S_AXI_RRESP;
    if (O_S_AXI_RVALID && I_S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (I_S_AXI_ARVALID && O_S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      if (I_S_AXI_ARADDR[AXI_ADDR_W-1:2] == OFFSET_STATUS[AXI_ADDR_W-1:2]) begin
        next_rdata = status_word;
      end else if (I_S_AXI_ARADDR[AXI_ADDR_W-1:2] != OFFSET_CONTROL[AXI_ADDR_W-1:2]) begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      O_S_AXI_AWREADY <= 1'b0;
      O_S_AXI_WREADY <= 1'b0;
      O_S_AXI_BVALID <= 1'b0;
      O_S_AXI_BRESP <= RESP_OKAY;
      boot_release <= 1'b0;
      O_S_AXI_ARREADY <= 1'b0;
      O_S_AXI_RVALID <= 1'b0;
      O_S_AXI_RDATA <= '0;
      O_S_AXI_RRESP <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      O_S_AXI_AWREADY <= next_awready;
      O_S_AXI_WREADY <= next_wready;
      O_S_AXI_BVALID <= next_bvalid;
      O_S_AXI_BRESP <= next_bresp;
      boot_release <= next_boot_release;
      O_S_AXI_ARREADY <= next_arready;
      O_S_AXI_RVALID <= next_rvalid;
      O_S_AXI_RDATA <= next_rdata;
      O_S_AXI_RRESP <= next_rresp;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  a_capture_in_reset: assert property (in_reset |=> captured == $past(strap_sync))
    else $error("strap capture missed a reset cycle");
  a_pulldown_zero: assert property (in_reset && strap_sync == '0 |=> captured == '0)
    else $error("undriven straps not captured as zero");
  a_boot_memory: assert property (
    state == ST_RESET && !in_reset && !captured[STRAP_BOOT] |=> O_BOOT_START ##1
    (!O_BOOT_START && O_CORE_RUN))
    else $error("memory boot did not start at reset release");
  a_idle_hold: assert property (
    state == ST_IDLE_WAIT && !boot_release && !in_reset |=> state == ST_IDLE_WAIT
    && !O_CORE_RUN && !O_BOOT_START)
    else $error("idle device left idle without release");
  a_irq_default: assert property (!captured[STRAP_IRQ] |=> O_EXT_IRQ_ENABLE == '0
    && O_EXT_IRQ_EDGE == '0)
    else $error("interrupts enabled with default strap");
  a_irq_enabled: assert property (
    state == ST_RESET && !in_reset && captured[STRAP_IRQ] |=> O_EXT_IRQ_ENABLE == '1
    && O_EXT_IRQ_EDGE == '1)
    else $error("interrupts not enabled at reset release");
  a_capture_hold: assert property (!in_reset && !$past(in_reset) |-> $stable(captured))
    else $error("captured straps changed outside reset");
  a_pins_float: assert property (in_reset |=> O_STRAP_PIN_OE == '0)
    else $error("shared pins driven during reset");

endmodule

/* File: hw/strap_pin_sync.sv */
// Three-stage synchroniser with an agreement filter for pin inputs.
// Assumes inputs are asynchronous to i_clk; output changes only when stages two and three agree.
`timescale 1ns/1ns
module strap_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  if (WIDTH < 1) begin : g_width_check
    $error("strap_pin_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb begin
    next_level = (stage2 & stage3) | (o_level & (stage2 ^ stage3));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      o_level <= next_level;
    end
  end

endmodule

/* File: hw/strap_sampler_pkg.sv */
// Constants shared by the strap sampler and its register slave.
// Assumes a single 10 MHz clock domain and a 32-bit AXI4-Lite register port.
package strap_sampler_pkg;

  // ************************************************************
  // Strap and shared pin positions
  // ************************************************************
  localparam int STRAP_COUNT = 4;
  localparam int STRAP_BOOT = 0;
  localparam int STRAP_IRQ = 1;
  localparam int STRAP_TEST_A = 2;
  localparam int STRAP_TEST_B = 3;
  localparam logic [3:0] STRAP_DEFAULT = 4'h0;
  localparam int EXT_IRQ_COUNT = 4;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] OFFSET_STATUS = 4'h0;
  localparam logic [3:0] OFFSET_CONTROL = 4'h4;
  localparam int STATUS_CAPTURED_LSB = 0;
  localparam int STATUS_IN_RESET = 4;
  localparam int STATUS_IDLE_WAIT = 5;
  localparam int STATUS_CORE_RUN = 6;
  localparam int STATUS_TEST_FAULT = 7;
  localparam int CONTROL_BOOT_RELEASE = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RESET,
    ST_BOOT_MEM,
    ST_IDLE_WAIT,
    ST_RUN
  } boot_state_t;

endpackage

/* File: verif/strap_board_model.sv */
// Board side of the shared strap pins: pull resistors and the resolved pin level.
// Assumes the device drives a pin only while its output enable is high.
`timescale 1ns/1ns
module strap_board_model (
  input wire logic [3:0] i_pull_high,
  input wire logic i_reserved_ok,
  input wire logic [3:0] i_dev_pin,
  input wire logic [3:0] i_dev_oe,
  output logic [3:0] o_level
);
  // ************************************************************
  // Pin resolution
  // ************************************************************
  logic [3:0] board_high;
  always_comb begin
    board_high = i_pull_high;
    if (!i_reserved_ok) begin
      board_high[3:2] = 2'h0;
    end
    for (int i = 0; i < 4; i++) begin
      // The resistors stay fitted, so the device output must win once enabled.
      o_level[i] = i_dev_oe[i] ? i_dev_pin[i] : board_high[i];
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the strap sampler with an AXI4-Lite register master.
// Assumes the board model resolves the strap pins and a 10 MHz clock.
`timescale 1ns/1ns
module tb_top
  import strap_sampler_pkg::*;
;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic core_rst_b = 1'b0;
  logic [3:0] pull = 4'h0, pin_func = 4'h0, level, dev_pin, dev_oe, en, edg;
  logic reserved_ok = 1'b0, boot, run, fault;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  int failures = 0, cmp_count = 0, cycles = 0, boot_cnt = 0, base = 0;

  always #50 clk = ~clk;

  reset_strap_mode_sampler reset_strap_mode_sampler_inst (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_CORE_RESET_B(core_rst_b), .I_STRAP_PIN(level),
    .I_PIN_FUNCTION(pin_func), .O_STRAP_PIN(dev_pin), .O_STRAP_PIN_OE(dev_oe),
    .O_BOOT_START(boot), .O_CORE_RUN(run), .O_EXT_IRQ_ENABLE(en), .O_EXT_IRQ_EDGE(edg),
    .O_TEST_STRAP_FAULT(fault), .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awvalid),
    .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(wstrb),
    .I_S_AXI_WVALID(wvalid), .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp),
    .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr),
    .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata),
    .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready));

  strap_board_model strap_board_model_inst (
    .i_pull_high(pull), .i_reserved_ok(reserved_ok), .i_dev_pin(dev_pin),
    .i_dev_oe(dev_oe), .o_level(level));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task test_done;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (boot === 1'b1) boot_cnt <= boot_cnt + 1;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  // ************************************************************
  // Bus master; ready and answers are sampled at the falling edge.
  // ************************************************************
  task axi_write(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, got;
    got = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!got) begin
      @(negedge clk);
      aw_t = awvalid && awready; w_t = wvalid && wready; got = bvalid; r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
    end
  endtask

  task axi_read(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, got;
    got = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!got) begin
      @(negedge clk);
      ar_t = arvalid && arready; got = rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task core_boot(input logic [3:0] s, input logic ok);
    @(posedge clk);
    core_rst_b <= 1'b0; pull <= s; reserved_ok <= ok;
    // The pins only fall back to the board pulls once the device has seen its reset.
    repeat (12) @(posedge clk);
    axi_read(OFFSET_STATUS, rd, rr);
    @(negedge clk);
    chk(rd[4:0], {1'b1, s});
    chk(dev_oe, 4'h0);
    base = boot_cnt;
    @(posedge clk) core_rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask

  task s_default;
    core_boot(4'h0, 1'b0);
    chk(boot_cnt - base, 1);
    chk(run, 1'b1);
    chk({en, edg}, 8'h00);
    chk(fault, 1'b0);
  endtask

  task s_idle;
    core_boot(4'h3, 1'b0);
    chk(boot_cnt - base, 0);
    chk(run, 1'b0);
    chk({en, edg}, 8'hFF);
    axi_read(OFFSET_STATUS, rd, rr);
    chk(rd[7:0], 8'h23);
    pin_func <= 4'hA;
    axi_write(OFFSET_CONTROL, 32'h1, rr);
    chk(rr, RESP_OKAY);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(run, 1'b1);
    chk({dev_oe, dev_pin}, 8'hFA);
    axi_read(OFFSET_STATUS, rd, rr);
    chk(rd[7:0], 8'h43);
  endtask

  task s_test;
    core_boot(4'hC, 1'b1);
    chk(fault, 1'b1);
    chk(boot_cnt - base, 1);
    axi_write(OFFSET_STATUS, 32'hFF, rr);
    chk(rr, RESP_OKAY);
    axi_read(OFFSET_STATUS, rd, rr);
    chk(rd[7:0], 8'hCC);
    axi_read(4'h8, rd, rr);
    chk(rr, RESP_SLVERR);
    axi_write(4'h8, 32'h1, rr);
    chk(rr, RESP_SLVERR);
    chk(run, 1'b1);
    axi_read(OFFSET_CONTROL, rd, rr);
    chk(rd, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    s_default();
    s_idle();
    s_test();
    test_done();
  end
endmodule
